// ### sdc_conv_ctrl.sv
// conversion control and result readout of the dual sampling converter
`timescale 1ns/10ps
`default_nettype none
module sdc_conv_ctrl
  import sdc_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CONV_HIGH = CONV_HIGH_CYC,
  parameter int CONV_SLEEP = CONV_SLEEP_CYC,
  parameter bit BIPOLAR = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conversion_start_n,
  input wire logic pair_select,
  input wire logic auto_sleep,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [DW-1:0] pair_a_input_1,
  input wire logic [DW-1:0] pair_a_input_2,
  input wire logic [DW-1:0] pair_b_input_1,
  input wire logic [DW-1:0] pair_b_input_2,
  output logic busy,
  output logic hold,
  output logic sleeping,
  output logic [DW-1:0] data_out,
  output logic data_oe_n
);
  if (CONV_HIGH < PUSH_CYC + 1 || CONV_SLEEP < PUSH_CYC + 1 ||
      CONV_SLEEP >= (1 << CNT_W) || CONV_HIGH >= (1 << CNT_W) || DW < 2)
  begin : g_bad_cfg
    $error("conversion lengths or data width out of range");
  end

  // output coding by variant
  // raw samples are straight binary; bipolar parts flip the top bit
  function automatic logic [DW-1:0] code_of(input logic [DW-1:0] raw);
    code_of = BIPOLAR ? {~raw[DW-1], raw[DW-2:0]} : raw;
  endfunction : code_of

  ////////////////////////////////////////////////////////////////////////////
  sdc_state_e state_q, state_d;
  logic start_n_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] len_q, len_d;
  logic pair_q, pair_d;
  logic [DW-1:0] held1_q, held1_d;
  logic [DW-1:0] held2_q, held2_d;
  logic rd_act_q;
  logic [DW-1:0] data_q;
  logic auto_sleep_q;

  wire start_fall = start_n_q && !conversion_start_n;
  wire can_start = (state_q == SDC_IDLE) || (state_q == SDC_SLEEP);
  wire take_start = start_fall && can_start;
  wire conv_last = (state_q == SDC_CONV) &&
    (cnt_q == len_q - CNT_W'(PUSH_CYC + 1));
  wire [DW-1:0] sel_in1 = pair_select ? pair_b_input_1 : pair_a_input_1;
  wire [DW-1:0] sel_in2 = pair_select ? pair_b_input_2 : pair_a_input_2;
  wire rd_act = !cs_n && !rd_n;
  wire rd_start = rd_act && !rd_act_q;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [DW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [DW-1:0] fifo_out_data;
  wire fifo_pop = rd_start && fifo_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    len_d = len_q;
    pair_d = pair_q;
    held1_d = held1_q;
    held2_d = held2_q;
    fifo_in_valid = 1'b0;
    fifo_in_data = held1_q;
    case (state_q)
      SDC_IDLE, SDC_SLEEP:
      begin
        if (take_start)
        begin
          state_d = SDC_CONV;
          cnt_d = '0;
          // pair chosen from level at the start edge
          pair_d = pair_select;
          held1_d = code_of(sel_in1);
          held2_d = code_of(sel_in2);
          len_d = auto_sleep ? CNT_W'(CONV_SLEEP) : CNT_W'(CONV_HIGH);
        end
      end
      SDC_CONV:
      begin
        cnt_d = cnt_q + 1'b1;
        if (conv_last)
          state_d = SDC_PUSH1;
      end
      SDC_PUSH1:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data = held1_q;
        if (fifo_in_ready)
          state_d = SDC_PUSH2;
      end
      SDC_PUSH2:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data = held2_q;
        // track resumes as the conversion ends
        if (fifo_in_ready)
          state_d = auto_sleep_q ? SDC_SLEEP : SDC_IDLE;
      end
      default:
        state_d = SDC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= SDC_IDLE;
      start_n_q <= 1'b1;
      cnt_q <= '0;
      len_q <= CNT_W'(CONV_HIGH);
      pair_q <= 1'b0;
      auto_sleep_q <= 1'b0;
      held1_q <= DW'(DATA_RST);
      held2_q <= DW'(DATA_RST);
    end
    else
    begin
      state_q <= state_d;
      start_n_q <= conversion_start_n;
      cnt_q <= cnt_d;
      len_q <= len_d;
      pair_q <= pair_d;
      held1_q <= held1_d;
      held2_q <= held2_d;
      if (take_start)
        auto_sleep_q <= auto_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a new start flushes unread words
  sdc_fifo #(
    .WIDTH(DW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(take_start),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // one 14-bit word per read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_act_q <= 1'b0;
      data_q <= DW'(DATA_RST);
    end
    else
    begin
      rd_act_q <= rd_act;
      if (fifo_pop)
        data_q <= fifo_out_data;
    end
  end

  assign busy = (state_q == SDC_CONV) || (state_q == SDC_PUSH1) ||
    (state_q == SDC_PUSH2);
  assign hold = busy;
  assign sleeping = state_q == SDC_SLEEP;
  assign data_out = data_q;
  // drive only under cs_n and rd_n low
  assign data_oe_n = !(rd_act && rd_act_q);
  // a start is taken as soon as busy is low; no extra dead time
  // acquisition wait is left to the host
  // quiet time before a start is left to the host

  ////////////////////////////////////////////////////////////////////////////
  // check helpers: busy length, input 1 still unread
  logic [CNT_W-1:0] busy_len_q;
  logic first_pend_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_len_q <= '0;
      first_pend_q <= 1'b0;
    end
    else
    begin
      busy_len_q <= busy ? busy_len_q + 1'b1 : '0;
      // a start flushes, so the next pop is input 1 again
      if (take_start)
        first_pend_q <= 1'b1;
      else if (fifo_pop)
        first_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    start_fall && can_start;
  endsequence

  sequence s_high_end;
    $fell(busy) ##0 !auto_sleep_q;
  endsequence

  sequence s_sleep_end;
    $fell(busy) ##0 auto_sleep_q;
  endsequence

  chk_busy_rise: assert property (@(posedge clk) disable iff (!nrst)
    s_start |=> busy)
    else $error("busy did not rise after start");

  chk_high_len: assert property (@(posedge clk) disable iff (!nrst)
    s_high_end |-> busy_len_q == CNT_W'(CONV_HIGH))
    else $error("high sampling conversion length wrong");

  chk_sleep_len: assert property (@(posedge clk) disable iff (!nrst)
    s_sleep_end |-> busy_len_q == CNT_W'(CONV_SLEEP))
    else $error("auto sleep conversion length wrong");

  chk_sleep_hold: assert property (@(posedge clk) disable iff (!nrst)
    sleeping && !take_start |=> sleeping)
    else $error("sleep left without a start");

  chk_sleep_after: assert property (@(posedge clk) disable iff (!nrst)
    $fell(busy) && auto_sleep_q |-> sleeping)
    else $error("no sleep after auto sleep conversion");

  chk_pair_take: assert property (@(posedge clk) disable iff (!nrst)
    s_start |=> pair_q == $past(pair_select))
    else $error("pair select not latched at start");

  chk_results_ready: assert property (@(posedge clk) disable iff (!nrst)
    $fell(busy) && !take_start |-> fifo_out_valid)
    else $error("results not ready when busy fell");

  chk_first_read: assert property (@(posedge clk) disable iff (!nrst)
    fifo_pop && first_pend_q |=> data_q == held1_q)
    else $error("first read is not input 1");

  chk_second_read: assert property (@(posedge clk) disable iff (!nrst)
    fifo_pop && !first_pend_q |=> data_q == held2_q)
    else $error("second read is not input 2");

  chk_track_end: assert property (@(posedge clk) disable iff (!nrst)
    state_q == SDC_PUSH2 && fifo_in_ready |=> !hold)
    else $error("track not resumed at conversion end");

  chk_oe_gate: assert property (@(posedge clk) disable iff (!nrst)
    (cs_n || rd_n) |-> data_oe_n)
    else $error("data driven without cs_n and rd_n low");

  chk_oe_read: assert property (@(posedge clk) disable iff (!nrst)
    rd_act && rd_act_q |-> !data_oe_n)
    else $error("data not driven during a read");

  chk_refuse_busy: assert property (@(posedge clk) disable iff (!nrst)
    start_fall && state_q == SDC_CONV && !conv_last |=>
      busy && $stable(pair_q) && $stable(len_q))
    else $error("start during conversion not ignored");

  chk_flush_start: assert property (@(posedge clk) disable iff (!nrst)
    s_start |=> !fifo_out_valid)
    else $error("old words survive a new start");
endmodule : sdc_conv_ctrl
`default_nettype wire

// ### sdc_pkg.sv
// constants and types shared by the dual converter control block
package sdc_pkg;
  localparam int DATA_W = 14;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_CONV_HIGH_NS = 5200;
  localparam int T_CONV_SLEEP_NS = 10000;
  localparam int T_ACQ_NS = 500;
  localparam int T_QUIET_NS = 400;
  // a conversion length is exact, so the plain quotient is used
  localparam int CONV_HIGH_CYC = T_CONV_HIGH_NS / CLK_PERIOD_NS;
  localparam int CONV_SLEEP_CYC = T_CONV_SLEEP_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_CYC = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int PUSH_CYC = 2;
  localparam logic [DATA_W-1:0] DATA_RST = 14'h0000;

  typedef enum logic [2:0] {
    SDC_IDLE = 3'b000,
    SDC_CONV = 3'b001,
    SDC_PUSH1 = 3'b010,
    SDC_PUSH2 = 3'b011,
    SDC_SLEEP = 3'b100
  } sdc_state_e;
endpackage : sdc_pkg

// ### sdc_fifo.sv
// result fifo with flush, valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sdc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  wire [AW:0] fill = wr_q - rd_q;

  assign in_ready = (fill != DEPTH[AW:0]) && !flush;
  assign out_valid = (fill != '0) && !flush;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (do_wr)
        wr_q <= wr_q + 1'b1;
      if (do_rd)
        rd_q <= rd_q + 1'b1;
    end
  end

  // storage has no reset; contents only count once written
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_full_no_write: assert property (@(posedge clk) disable iff (!nrst)
    fill == DEPTH[AW:0] |-> !in_ready)
    else $error("fifo accepts while full");
endmodule : sdc_fifo
`default_nettype wire

// ### sdc_host_model.sv
// host side model: starts conversions, reads results
`timescale 1ns/10ps
`default_nettype none
module sdc_host_model
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  output var logic conversion_start_n,
  output var logic pair_select,
  output var logic auto_sleep,
  output var logic cs_n,
  output var logic rd_n
);
  int idle_cyc = 0;
  initial
  begin
    conversion_start_n = 1'b1;
    pair_select = 1'b0;
    auto_sleep = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  always @(posedge clk)
    idle_cyc <= (busy || !(cs_n || rd_n)) ? 0 : idle_cyc + 1;
  ////////////////////////////////////////
  // early skips the wait, to provoke a refused start
  task automatic start_conv(input logic sel, input logic mode,
                            input bit early);
    logic moved;
    moved = sel != pair_select;
    while (!early && (idle_cyc < ACQ_CYC || idle_cyc < QUIET_CYC))
      @(negedge clk);
    pair_select = sel;
    auto_sleep = mode;
    @(negedge clk);
    // a changed pair gets its own acquisition time
    if (moved && !early)
      repeat (ACQ_CYC) @(negedge clk);
    conversion_start_n = 1'b0;
    @(negedge clk);
    conversion_start_n = 1'b1;
  endtask : start_conv
  task automatic read_word(output logic [DATA_W-1:0] w, output logic oe);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
    w = data_out;
    oe = data_oe_n;
    cs_n = 1'b1;
    rd_n = 1'b1;
    @(negedge clk);
  endtask : read_word
endmodule : sdc_host_model
`default_nettype wire

// ### testbench.sv
// testbench of the dual converter control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sdc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic conversion_start_n, pair_select, auto_sleep, cs_n, rd_n;
  logic busy, hold, sleeping, data_oe_n;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] a1 = 14'h0123;
  logic [DATA_W-1:0] a2 = 14'h1abc;
  logic [DATA_W-1:0] b1 = 14'h2f00;
  logic [DATA_W-1:0] b2 = 14'h3456;
  int bad_count = 0;
  int total_checks = 0;
  sdc_conv_ctrl i_sdc_conv_ctrl (
    .clk, .nrst, .conversion_start_n, .pair_select, .auto_sleep,
    .cs_n, .rd_n, .pair_a_input_1(a1), .pair_a_input_2(a2),
    .pair_b_input_1(b1), .pair_b_input_2(b2), .busy, .hold,
    .sleeping, .data_out, .data_oe_n
  );
  sdc_host_model i_sdc_host_model (
    .clk, .busy, .data_out, .data_oe_n, .conversion_start_n,
    .pair_select, .auto_sleep, .cs_n, .rd_n
  );
  initial
  begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic cmp_word(string n, logic [DATA_W-1:0] e,
                          logic [DATA_W-1:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word
  task automatic cmp_bit(string n, logic e, logic g);
    cmp_word(n, {13'h0000, e}, {13'h0000, g});
  endtask : cmp_bit
  task automatic cmp_count(string n, int e, int g);
    cmp_word(n, DATA_W'(e), DATA_W'(g));
  endtask : cmp_count
  // bipolar build: msb flipped to twos complement
  function automatic logic [DATA_W-1:0] code(logic [DATA_W-1:0] x);
    return {~x[DATA_W-1], x[DATA_W-2:0]};
  endfunction : code
  task automatic conv_len(output int n, output logic ok);
    n = 0;
    ok = 1'b1;
    // start_conv returns in the first busy cycle
    while (busy === 1'b1 && n < 4000)
    begin
      n++;
      ok = ok & (hold === busy);
      @(negedge clk);
    end
  endtask : conv_len
  task automatic rd(string n, logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] w;
    logic oe;
    i_sdc_host_model.read_word(w, oe);
    cmp_word(n, e, w);
    cmp_bit("oe during read", 1'b0, oe);
    cmp_bit("oe after read", 1'b1, data_oe_n);
  endtask : rd
  ////////////////////////////////////////
  task automatic t_reset();
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("hold", 1'b0, hold);
    cmp_bit("sleeping", 1'b0, sleeping);
    cmp_bit("oe idle", 1'b1, data_oe_n);
    cmp_word("data_out", DATA_RST, data_out);
    $display("test reset done");
  endtask : t_reset
  task automatic t_pair_a();
    int n;
    logic ok;
    i_sdc_host_model.start_conv(1'b0, 1'b0, 1'b0);
    conv_len(n, ok);
    cmp_count("high length", CONV_HIGH_CYC, n);
    cmp_bit("hold is busy", 1'b1, ok);
    cmp_bit("tracking", 1'b0, hold);
    cmp_bit("awake", 1'b0, sleeping);
    rd("a1", code(a1));
    rd("a2", code(a2));
    rd("third read", code(a2));
    $display("test pair a done");
  endtask : t_pair_a
  task automatic t_pair_b_sleep();
    int n;
    logic ok;
    i_sdc_host_model.start_conv(1'b1, 1'b1, 1'b0);
    b1 = ~b1;
    b2 = ~b2;
    conv_len(n, ok);
    cmp_count("sleep length", CONV_SLEEP_CYC, n);
    cmp_bit("asleep", 1'b1, sleeping);
    cmp_bit("tracking", 1'b0, hold);
    rd("b1", code(~b1));
    rd("b2", code(~b2));
    $display("test pair b sleep done");
  endtask : t_pair_b_sleep
  task automatic t_restart();
    int n;
    logic ok;
    i_sdc_host_model.start_conv(1'b0, 1'b0, 1'b0);
    conv_len(n, ok);
    rd("a1 once", code(a1));
    i_sdc_host_model.start_conv(1'b1, 1'b0, 1'b0);
    i_sdc_host_model.start_conv(1'b0, 1'b0, 1'b1);
    conv_len(n, ok);
    cmp_count("start in busy", CONV_HIGH_CYC - 2, n);
    cmp_bit("woken", 1'b0, sleeping);
    rd("b1 after restart", code(b1));
    $display("test restart done");
  endtask : t_restart
  task automatic t_oe();
    i_sdc_host_model.cs_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit("oe cs only", 1'b1, data_oe_n);
    i_sdc_host_model.cs_n = 1'b1;
    i_sdc_host_model.rd_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit("oe rd only", 1'b1, data_oe_n);
    i_sdc_host_model.rd_n = 1'b1;
    $display("test output enable done");
  endtask : t_oe
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_pair_a();
    t_pair_b_sleep();
    t_restart();
    t_oe();
    end_of_test();
  end
  // about 7000 cycles expected, margin kept
  initial
  begin
    #100000;
    bad_count++;
    $display("BAD watchdog expected done seen timeout");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
